/* File: lcc_regs.svh */
// register indexes, reset values and field positions of the line clock block
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH
`define LCC_ADDR_W 16
`define LCC_IDX_W 12
`define LCC_IDX_CTRL2 12'h0131
`define LCC_IDX_TXPAT 12'h0140
`define LCC_IDX_STATUS 12'h0141
`define LCC_IDX_IRQ_STAT 12'h0142
`define LCC_IDX_IRQ_CLR 12'h0143
`define LCC_IDX_IRQ_EN 12'h0144
`define LCC_CTRL2_RST 8'h00
`define LCC_TXPAT_RST 8'h00
`define LCC_IRQ_RST 2'h0
`define LCC_IRQ_W 2
`define LCC_IRQ_LOC_SET 0
`define LCC_IRQ_LOC_CLR 1
`define LCC_RESP_OKAY 2'h0
`define LCC_RESP_SLVERR 2'h2
`endif

/* File: lcc_pkg.sv */
// types of the line clock and carrier loss block
package lcc_pkg;
    typedef enum logic [1:0] {
        LCC_REF_12M96,
        LCC_REF_19M44,
        LCC_REF_51M84,
        LCC_REF_77M76
    } lcc_ref_rate_t;

    typedef struct packed {
        logic spare;
        logic tx_enable;
        logic redundant_active;
        logic use_timing_pair;
        logic synth_out_622;
        lcc_ref_rate_t ref_rate;
        logic synth_enable;
    } lcc_ctrl_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } lcc_pair_t;
endpackage : lcc_pkg

/* File: lcc_top.sv */
// line clock forwarding, carrier loss qualification and axi4-lite registers
// What this block does
// - primary data launches on falling negative clock leg
// - redundant data launches on rising positive leg
// - control byte two selects the clock source and stores synthesizer settings that drive no logic
// - primary carrier loss declares when primary active
// - primary carrier loss ignored when redundant active
// - redundant carrier loss counts only when redundant active
`timescale 1ns/1ps
`include "lcc_regs.svh"
module lcc_top
    import lcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`LCC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LCC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic synth_reference_in,
    input wire logic tx_timing_source_pos,
    input wire logic carrier_loss_primary_in,
    input wire logic carrier_loss_backup_in,
    output logic primary_fwd_clock_pos,
    output logic primary_fwd_clock_neg,
    output logic redundant_fwd_clock_pos,
    output logic redundant_fwd_clock_neg,
    output logic primary_line_data_pos,
    output logic primary_line_data_neg,
    output logic redundant_line_data_pos,
    output logic redundant_line_data_neg,
    output logic carrier_loss_declared,
    output logic irq
);
    function automatic logic [`LCC_IDX_W-1:0] reg_index(input logic [`LCC_ADDR_W-1:0] a);
        reg_index = a[`LCC_IDX_W+1:2];
    endfunction : reg_index

    lcc_ctrl_t ctrl_r;
    logic [7:0] txpat_r;
    logic [`LCC_IRQ_W-1:0] irq_stat_r, irq_en_r, irq_ev;
    logic [`LCC_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_held_r, w_held_r, do_write;
    logic [`LCC_IRQ_W-1:0] clr_pulse_r;

    // write path: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LCC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (reg_index(awaddr_r) == `LCC_IDX_CTRL2 ||
                    reg_index(awaddr_r) == `LCC_IDX_TXPAT ||
                    reg_index(awaddr_r) == `LCC_IDX_IRQ_CLR ||
                    reg_index(awaddr_r) == `LCC_IDX_IRQ_EN) ?
                    `LCC_RESP_OKAY : `LCC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    // register stores
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= lcc_ctrl_t'(`LCC_CTRL2_RST);
            txpat_r <= `LCC_TXPAT_RST;
            irq_en_r <= `LCC_IRQ_RST;
            clr_pulse_r <= `LCC_IRQ_RST;
        end else begin
            clr_pulse_r <= `LCC_IRQ_RST;
            if (do_write && wstrb_r[0]) begin
                if (reg_index(awaddr_r) == `LCC_IDX_CTRL2) begin
                    ctrl_r <= lcc_ctrl_t'(wdata_r[7:0]);
                end else if (reg_index(awaddr_r) == `LCC_IDX_TXPAT) begin
                    txpat_r <= wdata_r[7:0];
                end else if (reg_index(awaddr_r) == `LCC_IDX_IRQ_CLR) begin
                    clr_pulse_r <= wdata_r[`LCC_IRQ_W-1:0];
                end else if (reg_index(awaddr_r) == `LCC_IDX_IRQ_EN) begin
                    irq_en_r <= wdata_r[`LCC_IRQ_W-1:0];
                end
            end
        end
    end

    // read path
    logic [31:0] rd_word;
    logic rd_hit;
    logic los_p_s, los_b_s, loc_r;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (reg_index(s_axi_araddr) == `LCC_IDX_CTRL2) begin
            rd_word[7:0] = ctrl_r;
        end else if (reg_index(s_axi_araddr) == `LCC_IDX_TXPAT) begin
            rd_word[7:0] = txpat_r;
        end else if (reg_index(s_axi_araddr) == `LCC_IDX_STATUS) begin
            rd_word[2:0] = {los_b_s, los_p_s, loc_r};
        end else if (reg_index(s_axi_araddr) == `LCC_IDX_IRQ_STAT) begin
            rd_word[`LCC_IRQ_W-1:0] = irq_stat_r;
        end else if (reg_index(s_axi_araddr) == `LCC_IDX_IRQ_EN) begin
            rd_word[`LCC_IRQ_W-1:0] = irq_en_r;
        end else if (reg_index(s_axi_araddr) == `LCC_IDX_IRQ_CLR) begin
            rd_word = 32'h0000_0000;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `LCC_RESP_OKAY : `LCC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // synchronisers for every pin from outside the aclk domain
    logic [1:0] ref_sync_r, tpair_sync_r, los_p_sync_r, los_b_sync_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_sync_r <= 2'h0;
            tpair_sync_r <= 2'h0;
            los_p_sync_r <= 2'h0;
            los_b_sync_r <= 2'h0;
        end else begin
            ref_sync_r <= {ref_sync_r[0], synth_reference_in};
            tpair_sync_r <= {tpair_sync_r[0], tx_timing_source_pos};
            los_p_sync_r <= {los_p_sync_r[0], carrier_loss_primary_in};
            los_b_sync_r <= {los_b_sync_r[0], carrier_loss_backup_in};
        end
    end
    assign los_p_s = los_p_sync_r[1];
    assign los_b_s = los_b_sync_r[1];

    // line clock source: timing pair or reference input, always taken directly
    logic src_lvl, src_d_r, src_rise, src_fall;
    assign src_lvl = ctrl_r.use_timing_pair ? tpair_sync_r[1] : ref_sync_r[1];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_d_r <= 1'b0;
        end else begin
            src_d_r <= src_lvl;
        end
    end
    assign src_rise = src_lvl && !src_d_r;
    assign src_fall = !src_lvl && src_d_r;

    // forwarded clocks and data launch
    lcc_pair_t pfwd_r, rfwd_r;
    logic [2:0] bit_idx_r;
    logic data_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pfwd_r <= '{pos: 1'b0, neg: 1'b1};
            rfwd_r <= '{pos: 1'b0, neg: 1'b1};
        end else if (src_rise) begin
            pfwd_r <= '{pos: 1'b1, neg: 1'b0};
            rfwd_r <= '{pos: 1'b1, neg: 1'b0};
        end else if (src_fall) begin
            pfwd_r <= '{pos: 1'b0, neg: 1'b1};
            rfwd_r <= '{pos: 1'b0, neg: 1'b1};
        end
    end

    // data moves only with the falling negative / rising positive legs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_idx_r <= 3'h0;
            data_r <= 1'b0;
        end else if (src_rise) begin
            data_r <= ctrl_r.tx_enable & txpat_r[bit_idx_r];
            bit_idx_r <= bit_idx_r + 3'h1;
        end
    end
    assign primary_fwd_clock_pos = pfwd_r.pos;
    assign primary_fwd_clock_neg = pfwd_r.neg;
    assign redundant_fwd_clock_pos = rfwd_r.pos;
    assign redundant_fwd_clock_neg = rfwd_r.neg;
    assign primary_line_data_pos = data_r;
    assign redundant_line_data_pos = data_r;
    logic data_n_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_n_r <= 1'b1;
        end else if (src_rise) begin
            data_n_r <= !(ctrl_r.tx_enable & txpat_r[bit_idx_r]);
        end
    end
    assign primary_line_data_neg = data_n_r;
    assign redundant_line_data_neg = data_n_r;

    // carrier loss qualified by the active port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loc_r <= 1'b0;
        end else begin
            loc_r <= ctrl_r.redundant_active ? los_b_s : los_p_s;
        end
    end
    assign carrier_loss_declared = loc_r;

    // interrupt: sticky events, set wins over clear
    assign irq_ev = {!(ctrl_r.redundant_active ? los_b_s : los_p_s) && loc_r,
                     (ctrl_r.redundant_active ? los_b_s : los_p_s) && !loc_r};
    logic irq_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= `LCC_IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~clr_pulse_r) | irq_ev;
            irq_r <= |(((irq_stat_r & ~clr_pulse_r) | irq_ev) & irq_en_r);
        end
    end
    assign irq = irq_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pri_launch_edge: assert property ($changed(primary_line_data_pos) |->
        $fell(primary_fwd_clock_neg)) else $error("primary data off negative leg fall");
    a_red_launch_edge: assert property ($changed(redundant_line_data_pos) |->
        $rose(redundant_fwd_clock_pos)) else $error("redundant data off positive leg rise");
    a_src_follow: assert property (src_rise |=> primary_fwd_clock_pos &&
        !primary_fwd_clock_neg && redundant_fwd_clock_pos) else $error("fwd clock missed edge");
    a_loc_primary: assert property (!ctrl_r.redundant_active && los_p_s |=>
        carrier_loss_declared) else $error("primary loss not declared");
    a_ign_primary: assert property (ctrl_r.redundant_active && !los_b_s |=>
        !carrier_loss_declared) else $error("primary input not ignored");
    a_ign_backup: assert property (!ctrl_r.redundant_active && !los_p_s |=>
        !carrier_loss_declared) else $error("backup input not ignored");
    a_sync_depth: assert property ($rose(los_p_s) |->
        $past(carrier_loss_primary_in, 2)) else $error("primary loss skipped synchroniser");
    a_loc_latency: assert property (!ctrl_r.redundant_active &&
        $rose(carrier_loss_primary_in) ##1 !ctrl_r.redundant_active [*2] ##0
        carrier_loss_primary_in |=> carrier_loss_declared) else $error("loss latency wrong");
    a_irq_level: assert property ((irq_stat_r & irq_en_r) != '0 && clr_pulse_r == '0 |=>
        irq) else $error("irq low with enabled status");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

    c_loc_primary: cover property (!ctrl_r.redundant_active && $rose(carrier_loss_declared));
    c_loc_backup: cover property (ctrl_r.redundant_active && $rose(carrier_loss_declared));
    c_data_launch: cover property (src_rise ##1 $changed(primary_line_data_pos));
    c_irq_raise: cover property ($rose(irq));
endmodule : lcc_top

/* File: lcc_xcvr_model.sv */
// transceiver model: reference clock and carrier loss levels
`timescale 1ns/1ps
module lcc_xcvr_model (
    input wire logic clk_run,
    input wire logic loss_primary,
    input wire logic loss_backup,
    output logic synth_reference_in,
    output logic tx_timing_source_pos,
    output logic carrier_loss_primary_in,
    output logic carrier_loss_backup_in
);
    // 200 ns period stands in for the line reference; held still while idle
    initial synth_reference_in = 1'b0;
    always #100 synth_reference_in = clk_run ? ~synth_reference_in : 1'b0;
    // timing pair held low, so it stays quiet when the bench selects it
    assign tx_timing_source_pos = 1'b0;
    assign carrier_loss_primary_in = loss_primary;
    assign carrier_loss_backup_in = loss_backup;
endmodule : lcc_xcvr_model

/* File: lcc_top_tb_top.sv */
// self-checking bench for the line clock and carrier loss block
`timescale 1ns/1ps
`include "lcc_regs.svh"
module lcc_top_tb_top;
    import lcc_pkg::*;
    localparam logic [15:0] A_CTRL2 = 16'h04c4;
    localparam logic [15:0] A_TXPAT = 16'h0500;
    localparam logic [15:0] A_STAT = 16'h0504;
    localparam logic [15:0] A_ISTAT = 16'h0508;
    localparam logic [15:0] A_ICLR = 16'h050c;
    localparam logic [15:0] A_IEN = 16'h0510;
    localparam logic [7:0] TX_PAT = 8'ha5;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ref_in, tsrc, lp_in, lb_in, run, cmd_lp, cmd_lb, mon_en, pd_prev, pn_prev, rp_prev;
    logic pfp, pfn, rfp, rfn, pdp, pdn, rdp, rdn, loss, irq;
    int miscompares = 0;
    int total_checks = 0;
    int toggles = 0;
    int falls = 0;
    int falls_before = 0;
    logic [2:0] bit_no = 3'h0;

    lcc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .synth_reference_in(ref_in), .tx_timing_source_pos(tsrc),
        .carrier_loss_primary_in(lp_in), .carrier_loss_backup_in(lb_in),
        .primary_fwd_clock_pos(pfp), .primary_fwd_clock_neg(pfn), .redundant_fwd_clock_pos(rfp),
        .redundant_fwd_clock_neg(rfn), .primary_line_data_pos(pdp), .primary_line_data_neg(pdn),
        .redundant_line_data_pos(rdp), .redundant_line_data_neg(rdn),
        .carrier_loss_declared(loss), .irq(irq));
    lcc_xcvr_model u_xcvr (.clk_run(run), .loss_primary(cmd_lp), .loss_backup(cmd_lb),
        .synth_reference_in(ref_in), .tx_timing_source_pos(tsrc),
        .carrier_loss_primary_in(lp_in), .carrier_loss_backup_in(lb_in));

    always #12.5 aclk = ~aclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input string what, input logic [15:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        chk(what, ed, s_axi_rdata);
        chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // data may only move where the forwarded clocks give their launch edge
    always @(posedge aclk) begin
        if (mon_en) begin
            if (pdp !== pd_prev) begin
                toggles++;
                chk("primary launch edge", 2'b10, {pn_prev, pfn});
                chk("redundant launch edge", 2'b01, {rp_prev, rfp});
            end
            if (pn_prev && !pfn) begin
                falls++;
                chk("primary data bit", {31'h0, TX_PAT[bit_no]}, {31'h0, pdp});
                chk("redundant data bit", {31'h0, TX_PAT[bit_no]}, {31'h0, rdp});
                bit_no++;
            end
            chk("line pairs", 4'hf, {pdp ^ pdn, rdp ^ rdn, pfp ^ pfn, rfp ^ rfn});
        end
        pd_prev = pdp;
        pn_prev = pfn;
        rp_prev = rfp;
    end

    initial begin
        #500000;
        miscompares++;
        end_sim();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 16'h0000;
        s_axi_araddr = 16'h0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        {run, cmd_lp, cmd_lb, mon_en} = 4'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd("ctrl2 reset", A_CTRL2, 32'h0000_0000, `LCC_RESP_OKAY);
        rd("irq enable reset", A_IEN, 32'h0000_0000, `LCC_RESP_OKAY);
        rd("irq status reset", A_ISTAT, 32'h0000_0000, `LCC_RESP_OKAY);
        rd("unmapped read", 16'h0600, 32'h0000_0000, `LCC_RESP_SLVERR);
        wr(16'h0600, 32'h0000_00ff, `LCC_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(A_CTRL2, {24'h0, 5'h01, i[1:0], 1'b1}, `LCC_RESP_OKAY);
            rd("ctrl2 rate", A_CTRL2, {24'h0, 5'h01, i[1:0], 1'b1}, `LCC_RESP_OKAY);
        end
        wr(A_CTRL2, 32'h0000_0000, `LCC_RESP_OKAY);
        wr(A_IEN, 32'h0000_0001, `LCC_RESP_OKAY);
        cmd_lb <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("backup ignored", 0, loss);
        cmd_lp <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("primary loss", 1, loss);
        chk("irq raised", 1, irq);
        rd("status", A_STAT, 32'h0000_0007, `LCC_RESP_OKAY);
        wr(A_CTRL2, 32'h0000_0020, `LCC_RESP_OKAY);
        cmd_lb <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("primary ignored", 0, loss);
        cmd_lb <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("backup loss", 1, loss);
        {cmd_lp, cmd_lb} <= 2'b00;
        repeat (8) @(posedge aclk);
        rd("irq status", A_ISTAT, 32'h0000_0003, `LCC_RESP_OKAY);
        wr(A_IEN, 32'h0000_0000, `LCC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq masked", 0, irq);
        wr(A_IEN, 32'h0000_0002, `LCC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq enabled", 1, irq);
        wr(A_ICLR, 32'h0000_0003, `LCC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 0, irq);
        rd("irq clear reads zero", A_ICLR, 32'h0000_0000, `LCC_RESP_OKAY);
        rd("irq status cleared", A_ISTAT, 32'h0000_0000, `LCC_RESP_OKAY);
        wr(A_TXPAT, 32'h0000_00a5, `LCC_RESP_OKAY);
        wr(A_CTRL2, 32'h0000_0040, `LCC_RESP_OKAY);
        mon_en <= 1'b1;
        run <= 1'b1;
        repeat (400) @(posedge aclk);
        run <= 1'b0;
        mon_en <= 1'b0;
        chk("data toggled", 1, toggles > 0);
        chk("clock falls", 1, falls >= 45 && falls <= 51);
        // quiet timing pair selected: the forwarded clock must stand still
        wr(A_CTRL2, 32'h0000_0050, `LCC_RESP_OKAY);
        falls_before = falls;
        {run, mon_en} <= 2'b11;
        repeat (100) @(posedge aclk);
        {run, mon_en} <= 2'b00;
        chk("timing pair quiet", falls_before, falls);
        end_sim();
    end
endmodule : lcc_top_tb_top
